// ---- eamd_defines.vh ----
// Constants shared by the effective address mode decoder files.
`ifndef EAMD_DEFINES_VH
`define EAMD_DEFINES_VH

// Register byte offsets on the AHB-Lite slave.
`define EAMD_OFS_CTRL      8'h00
`define EAMD_OFS_OPERAND   8'h04
`define EAMD_OFS_RESULT    8'h08
`define EAMD_OFS_STATUS    8'h0C

// Reset values.
`define EAMD_CTRL_RST      1'b0
`define EAMD_OPERAND_RST   19'h00000
`define EAMD_RESULT_RST    22'h000000

// Operand register fields.
`define EAMD_OP_MODRM_LSB  0
`define EAMD_OP_SIB_LSB    8
`define EAMD_OP_ADDR32_BIT 16
`define EAMD_OP_DATA32_BIT 17
`define EAMD_OP_WIDTH_BIT  18
`define EAMD_OP_W          19

// Result register fields.
`define EAMD_RES_REGOP_BIT 0
`define EAMD_RES_REGN_LSB  1
`define EAMD_RES_KIND_LSB  4
`define EAMD_RES_BVLD_BIT  6
`define EAMD_RES_BASE_LSB  7
`define EAMD_RES_IVLD_BIT  10
`define EAMD_RES_INDEX_LSB 11
`define EAMD_RES_SCALE_LSB 14
`define EAMD_RES_DLEN_LSB  16
`define EAMD_RES_STACK_BIT 19
`define EAMD_RES_SIB_BIT   20
`define EAMD_RES_UNDEF_BIT 21
`define EAMD_RES_W         22

// Status register fields.
`define EAMD_STS_DONE_BIT  0
`define EAMD_STS_UNDEF_BIT 1
`define EAMD_STS_CNT_LSB   16

// Mode field codes.
`define EAMD_MOD_NODISP    2'h0
`define EAMD_MOD_DISP8     2'h1
`define EAMD_MOD_DISPW     2'h2
`define EAMD_MOD_REG       2'h3

// Special r/m, index and base codes.
`define EAMD_RM_SIB        3'h4
`define EAMD_RM_DIRECT32   3'h5
`define EAMD_RM_DIRECT16   3'h6
`define EAMD_IDX_NONE      3'h4
`define EAMD_GPR3          3'h3
`define EAMD_GPR4          3'h4
`define EAMD_GPR5          3'h5
`define EAMD_GPR6          3'h6
`define EAMD_GPR7          3'h7

// Displacement lengths in bytes.
`define EAMD_DLEN_NONE     3'h0
`define EAMD_DLEN_BYTE     3'h1
`define EAMD_DLEN_HALF     3'h2
`define EAMD_DLEN_WORD     3'h4

// Register operand kinds.
`define EAMD_KIND_LOW8     2'h0
`define EAMD_KIND_HIGH8    2'h1
`define EAMD_KIND_16       2'h2
`define EAMD_KIND_32       2'h3

`endif

// ---- eamd_reg_operand.v ----
// Register operand selection for the register form of the addressing byte.
`timescale 1ns/100ps
`include "eamd_defines.vh"

module eamd_reg_operand (
  input  wire [2:0] rm_i,
  input  wire       width_i,
  input  wire       data32_i,
  output reg  [2:0] num_o,
  output reg  [1:0] kind_o
);

  always @* begin
    if (width_i) begin
      num_o  = rm_i;
      kind_o = data32_i ? `EAMD_KIND_32 : `EAMD_KIND_16;
    end else begin
      // Byte codes 4-7 reach the high byte of registers 0-3.
      num_o  = {1'b0, rm_i[1:0]};
      kind_o = rm_i[2] ? `EAMD_KIND_HIGH8 : `EAMD_KIND_LOW8;
    end
  end

endmodule

// ---- eamd_mem_decode.v ----
// Memory form decode of the addressing bytes into base, index, displacement.
`timescale 1ns/100ps
`include "eamd_defines.vh"

module eamd_mem_decode (
  input  wire [7:0] modrm_i,
  input  wire [7:0] sib_i,
  input  wire       addr32_i,
  output reg        base_vld_o,
  output reg  [2:0] base_o,
  output reg        index_vld_o,
  output reg  [2:0] index_o,
  output reg  [1:0] scale_o,
  output reg  [2:0] disp_len_o,
  output reg        seg_stack_o,
  output reg        sib_used_o,
  output reg        undef_o
);

  wire [1:0] md  = modrm_i[7:6];
  wire [2:0] rm  = modrm_i[2:0];
  wire [1:0] ss  = sib_i[7:6];
  wire [2:0] idx = sib_i[5:3];
  wire [2:0] bs  = sib_i[2:0];

  always @* begin
    base_vld_o  = 1'b0;
    base_o      = 3'h0;
    index_vld_o = 1'b0;
    index_o     = 3'h0;
    scale_o     = 2'h0;
    disp_len_o  = `EAMD_DLEN_NONE;
    seg_stack_o = 1'b0;
    sib_used_o  = 1'b0;
    undef_o     = 1'b0;
    if (md == `EAMD_MOD_REG) begin
      disp_len_o = `EAMD_DLEN_NONE;
    end else if (!addr32_i) begin
      // 16-bit tables.
      if (md == `EAMD_MOD_DISP8)
        disp_len_o = `EAMD_DLEN_BYTE;
      else if (md == `EAMD_MOD_DISPW)
        disp_len_o = `EAMD_DLEN_HALF;
      base_vld_o = 1'b1;
      case (rm)
        3'h0: begin
          base_o = `EAMD_GPR3; index_vld_o = 1'b1; index_o = `EAMD_GPR6;
        end
        3'h1: begin
          base_o = `EAMD_GPR3; index_vld_o = 1'b1; index_o = `EAMD_GPR7;
        end
        3'h2: begin
          base_o = `EAMD_GPR5; index_vld_o = 1'b1; index_o = `EAMD_GPR6;
        end
        3'h3: begin
          base_o = `EAMD_GPR5; index_vld_o = 1'b1; index_o = `EAMD_GPR7;
        end
        3'h4: base_o = `EAMD_GPR6;
        3'h5: base_o = `EAMD_GPR7;
        3'h6: begin
          if (md == `EAMD_MOD_NODISP) begin
            base_vld_o = 1'b0;
            disp_len_o = `EAMD_DLEN_HALF;
          end else begin
            base_o = `EAMD_GPR5;
          end
        end
        default: base_o = `EAMD_GPR3;
      endcase
      seg_stack_o = base_vld_o && (base_o == `EAMD_GPR5);
    end else begin
      // 32-bit tables.
      if (md == `EAMD_MOD_DISP8)
        disp_len_o = `EAMD_DLEN_BYTE;
      else if (md == `EAMD_MOD_DISPW)
        disp_len_o = `EAMD_DLEN_WORD;
      if (rm == `EAMD_RM_SIB) begin
        sib_used_o  = 1'b1;
        base_vld_o  = 1'b1;
        base_o      = bs;
        scale_o     = ss;
        index_vld_o = (idx != `EAMD_IDX_NONE);
        index_o     = idx;
        // The address is undefined here; flagged, not corrected.
        undef_o = (idx == `EAMD_IDX_NONE) && (ss != 2'h0);
        if (md == `EAMD_MOD_NODISP && bs == `EAMD_GPR5) begin
          base_vld_o = 1'b0;
          disp_len_o = `EAMD_DLEN_WORD;
        end
        seg_stack_o = base_vld_o &&
                      (bs == `EAMD_GPR4 || bs == `EAMD_GPR5);
      end else if (md == `EAMD_MOD_NODISP && rm == `EAMD_RM_DIRECT32) begin
        disp_len_o = `EAMD_DLEN_WORD;
      end else begin
        base_vld_o  = 1'b1;
        base_o      = rm;
        seg_stack_o = (rm == `EAMD_GPR5);
      end
    end
  end

endmodule

// ---- eamd_top.v ----
// Effective address mode decoder with pipeline ports and an AHB-Lite slave.
//
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/100ps
`include "eamd_defines.vh"

////////////////////////////////////////////////////////////////////////////////
module eamd_top (
  input  wire        clk_i,
  input  wire        rst_b_i,
  // Pipeline request from the opcode decode stage.
  input  wire        dec_valid_i,
  input  wire [7:0]  modrm_i,
  input  wire [7:0]  sib_i,
  input  wire        addr32_i,
  input  wire        data32_i,
  input  wire        width_i,
  // Decoded result towards address generation.
  output wire        res_valid_o,
  output wire        reg_op_o,
  output wire [2:0]  reg_num_o,
  output wire [1:0]  reg_kind_o,
  output wire        base_vld_o,
  output wire [2:0]  base_o,
  output wire        index_vld_o,
  output wire [2:0]  index_o,
  output wire [1:0]  scale_o,
  output wire [2:0]  disp_len_o,
  output wire        seg_stack_o,
  output wire        sib_used_o,
  output wire        undef_o,
  // AHB-Lite slave.
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output wire [31:0] hrdata_o,
  output wire        hreadyout_o,
  output wire        hresp_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave state.

  reg        hreadyout_q;
  reg [31:0] hrdata_q;
  reg        rd_pend_q;
  reg        wr_pend_q;
  reg [7:0]  addr_q;

  // Software visible registers.
  reg                     sw_mode_q;
  reg [`EAMD_OP_W-1:0]    opnd_q;
  reg                     sw_go_q;
  reg                     done_q;
  reg [15:0]              cnt_q;

  // Result registers.
  reg [`EAMD_RES_W-1:0]   res_q;
  reg                     res_valid_q;

  // A transfer is taken only when selected, non-idle and the bus is ready.
  // The size is not checked: only whole word transfers are supported.
  wire acc    = hsel_i & htrans_i[1] & hready_i;
  wire wr_en  = wr_pend_q;
  wire wr_ctl = wr_en && (addr_q == `EAMD_OFS_CTRL);
  wire wr_opd = wr_en && (addr_q == `EAMD_OFS_OPERAND);
  wire wr_sts = wr_en && (addr_q == `EAMD_OFS_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Decode source selection.

  wire [7:0] src_modrm  = sw_mode_q ? opnd_q[`EAMD_OP_MODRM_LSB +: 8]
                                    : modrm_i;
  wire [7:0] src_sib    = sw_mode_q ? opnd_q[`EAMD_OP_SIB_LSB +: 8] : sib_i;
  wire       src_addr32 = sw_mode_q ? opnd_q[`EAMD_OP_ADDR32_BIT] : addr32_i;
  wire       src_data32 = sw_mode_q ? opnd_q[`EAMD_OP_DATA32_BIT] : data32_i;
  wire       src_width  = sw_mode_q ? opnd_q[`EAMD_OP_WIDTH_BIT] : width_i;
  // In software mode the pipeline request is ignored, so a test program
  // cannot be disturbed by stray traffic from the decode stage.
  wire       dec_go     = sw_mode_q ? sw_go_q : dec_valid_i;

  ////////////////////////////////////////////////////////////////////////////
  // Decode datapath.

  // Both decoders run on every cycle; the mode field alone picks which
  // result is kept.  Keeping them apart lets each be checked on its own,
  // at the cost of a few gates that idle for the other form.

  wire       m_bvld;
  wire [2:0] m_base;
  wire       m_ivld;
  wire [2:0] m_index;
  wire [1:0] m_scale;
  wire [2:0] m_dlen;
  wire       m_stack;
  wire       m_sib;
  wire       m_undef;
  wire [2:0] r_num;
  wire [1:0] r_kind;

  eamd_mem_decode u_mem (
    .modrm_i     (src_modrm),
    .sib_i       (src_sib),
    .addr32_i    (src_addr32),
    .base_vld_o  (m_bvld),
    .base_o      (m_base),
    .index_vld_o (m_ivld),
    .index_o     (m_index),
    .scale_o     (m_scale),
    .disp_len_o  (m_dlen),
    .seg_stack_o (m_stack),
    .sib_used_o  (m_sib),
    .undef_o     (m_undef)
  );

  eamd_reg_operand u_reg (
    .rm_i     (src_modrm[2:0]),
    .width_i  (src_width),
    .data32_i (src_data32),
    .num_o    (r_num),
    .kind_o   (r_kind)
  );

  wire is_reg = (src_modrm[7:6] == `EAMD_MOD_REG);

  reg [`EAMD_RES_W-1:0] res_d;

  always @* begin
    res_d = `EAMD_RESULT_RST;
    res_d[`EAMD_RES_REGOP_BIT] = is_reg;
    if (is_reg) begin
      // Memory fields stay zero for a register operand.
      res_d[`EAMD_RES_REGN_LSB +: 3] = r_num;
      res_d[`EAMD_RES_KIND_LSB +: 2] = r_kind;
    end else begin
      res_d[`EAMD_RES_BVLD_BIT]       = m_bvld;
      res_d[`EAMD_RES_BASE_LSB +: 3]  = m_base;
      res_d[`EAMD_RES_IVLD_BIT]       = m_ivld;
      res_d[`EAMD_RES_INDEX_LSB +: 3] = m_index;
      res_d[`EAMD_RES_SCALE_LSB +: 2] = m_scale;
      res_d[`EAMD_RES_DLEN_LSB +: 3]  = m_dlen;
      res_d[`EAMD_RES_STACK_BIT]      = m_stack;
      res_d[`EAMD_RES_SIB_BIT]        = m_sib;
      res_d[`EAMD_RES_UNDEF_BIT]      = m_undef;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result capture.

  // The result fields hold their last value between requests, so address
  // generation may read them at leisure; res_valid_o marks only the cycle
  // in which a new decode lands.  Memory fields are zero for a register
  // operand and register fields zero for a memory operand, which keeps
  // the unused fields from toggling.

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      res_q       <= `EAMD_RESULT_RST;
      res_valid_q <= 1'b0;
      cnt_q       <= 16'h0000;
    end else begin
      res_valid_q <= dec_go;
      if (dec_go) begin
        res_q <= res_d;
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers.

  // Register map, one aligned word each, only haddr[7:0] decoded:
  //   0x00 control: bit 0 selects software mode, which mutes the pipeline.
  //   0x04 operand: addressing byte [7:0], sib byte [15:8], 32-bit
  //        addressing [16], 32-bit data [17], width bit [18].
  //   0x08 result: the captured decode, read only, laid out as res_q.
  //   0x0C status: done [0], undefined address [1], decode count [31:16].
  // Unmapped offsets read as zero and ignore writes, so a driver probing
  // the block never disturbs a decode in progress.
  //
  // Done is cleared by writing one to bit 0 of status.  A software decode
  // that completes in the same cycle as the clear wins, so a finished
  // result is never hidden from the program polling for it.
  //
  // The decode count counts pipeline and software decodes alike and wraps
  // silently; software must read it often enough to spot the wrap.

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      sw_mode_q <= `EAMD_CTRL_RST;
      opnd_q    <= `EAMD_OPERAND_RST;
      sw_go_q   <= 1'b0;
      done_q    <= 1'b0;
    end else begin
      if (wr_ctl)
        sw_mode_q <= hwdata_i[0];
      if (wr_opd)
        opnd_q <= hwdata_i[`EAMD_OP_W-1:0];
      // Writing the operand starts one decode when in software mode.
      sw_go_q <= wr_opd & sw_mode_q;
      // A decode finishing in the cycle of a clear keeps the flag set.
      if (sw_mode_q && sw_go_q)
        done_q <= 1'b1;
      else if (wr_sts && hwdata_i[`EAMD_STS_DONE_BIT])
        done_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave timing.

  // The write data phase never stalls: the register updates at the edge
  // that ends it.  A read costs one wait state and the slave always
  // answers OKAY, as there is no access that it could refuse.

  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    case (addr_q)
      `EAMD_OFS_CTRL:    rd_mux[0] = sw_mode_q;
      `EAMD_OFS_OPERAND: rd_mux[`EAMD_OP_W-1:0] = opnd_q;
      `EAMD_OFS_RESULT:  rd_mux[`EAMD_RES_W-1:0] = res_q;
      `EAMD_OFS_STATUS: begin
        rd_mux[`EAMD_STS_DONE_BIT]     = done_q;
        rd_mux[`EAMD_STS_UNDEF_BIT]    = res_q[`EAMD_RES_UNDEF_BIT];
        rd_mux[`EAMD_STS_CNT_LSB +: 16] = cnt_q;
      end
      default:           rd_mux = 32'h00000000;
    endcase
  end

  // Reads take one wait state so that read data always reflects a write
  // completed in the data phase just before.
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      hreadyout_q <= 1'b1;
      hrdata_q    <= 32'h00000000;
      rd_pend_q   <= 1'b0;
      wr_pend_q   <= 1'b0;
      addr_q      <= 8'h00;
    end else begin
      rd_pend_q   <= acc & ~hwrite_i;
      wr_pend_q   <= acc & hwrite_i;
      hreadyout_q <= ~(acc & ~hwrite_i);
      if (acc)
        addr_q <= haddr_i[7:0];
      if (rd_pend_q)
        hrdata_q <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign hrdata_o    = hrdata_q;
  assign hreadyout_o = hreadyout_q;
  assign hresp_o     = 1'b0;

  assign res_valid_o = res_valid_q;
  assign reg_op_o    = res_q[`EAMD_RES_REGOP_BIT];
  assign reg_num_o   = res_q[`EAMD_RES_REGN_LSB +: 3];
  assign reg_kind_o  = res_q[`EAMD_RES_KIND_LSB +: 2];
  assign base_vld_o  = res_q[`EAMD_RES_BVLD_BIT];
  assign base_o      = res_q[`EAMD_RES_BASE_LSB +: 3];
  assign index_vld_o = res_q[`EAMD_RES_IVLD_BIT];
  assign index_o     = res_q[`EAMD_RES_INDEX_LSB +: 3];
  assign scale_o     = res_q[`EAMD_RES_SCALE_LSB +: 2];
  assign disp_len_o  = res_q[`EAMD_RES_DLEN_LSB +: 3];
  assign seg_stack_o = res_q[`EAMD_RES_STACK_BIT];
  assign sib_used_o  = res_q[`EAMD_RES_SIB_BIT];
  assign undef_o     = res_q[`EAMD_RES_UNDEF_BIT];

endmodule

// ---- eamd_top_asserts.sv ----
// Concurrent checks on the pipeline ports of the address mode decoder.
`timescale 1ns/100ps
module eamd_top_asserts (
  input wire        clk_i,
  input wire        rst_b_i,
  input wire        dec_valid_i,
  input wire [7:0]  modrm_i,
  input wire [7:0]  sib_i,
  input wire        addr32_i,
  input wire        data32_i,
  input wire        width_i,
  input wire        hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0]  htrans_i,
  input wire        hwrite_i,
  input wire [31:0] hwdata_i,
  input wire        hready_i,
  input wire        res_valid_o,
  input wire        reg_op_o,
  input wire [2:0]  reg_num_o,
  input wire [1:0]  reg_kind_o,
  input wire        base_vld_o,
  input wire [2:0]  base_o,
  input wire        index_vld_o,
  input wire [1:0]  scale_o,
  input wire [2:0]  disp_len_o,
  input wire        seg_stack_o,
  input wire        sib_used_o
);
  // Software mode is mirrored from bus writes, as it mutes the pipeline.
  logic       wc_q, sw_q, took_q, a_q, d_q, w_q;
  logic [7:0] m_q, s_q;
  wire  [2:0] dl;
  ////////////////////////////////
  always @(posedge clk_i) begin
    m_q <= modrm_i;
    s_q <= sib_i;
    a_q <= addr32_i;
    d_q <= data32_i;
    w_q <= width_i;
    if (!rst_b_i) begin
      wc_q <= 1'b0;
      sw_q <= 1'b0;
      took_q <= 1'b0;
    end else begin
      wc_q <= hsel_i & htrans_i[1] & hready_i & hwrite_i &
              (haddr_i[7:0] == 8'h00);
      if (wc_q && hready_i)
        sw_q <= hwdata_i[0];
      took_q <= dec_valid_i & ~sw_q;
    end
  end
  assign dl = (m_q[7:6] == 2'h1) ? 3'h1 :
              (m_q[7:6] == 2'h2) ? (a_q ? 3'h4 : 3'h2) :
              !a_q ? ((m_q[2:0] == 3'h6) ? 3'h2 : 3'h0) :
              (m_q[2:0] == 3'h5 || (m_q[2:0] == 3'h4 && s_q[2:0] == 3'h5))
              ? 3'h4 : 3'h0;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////
  a_result_timing: assert property (took_q |-> res_valid_o)
    else $error("no result one cycle after request");
  a_reg_select: assert property (
    took_q |-> reg_op_o == (m_q[7:6] == 2'h3))
    else $error("register form wrong for mode");
  a_byte_reg: assert property (took_q && reg_op_o && !w_q |->
    reg_num_o == {1'b0, m_q[1:0]} && reg_kind_o == {1'b0, m_q[2]})
    else $error("byte register wrong");
  a_full_reg: assert property (took_q && reg_op_o && w_q |->
    reg_num_o == m_q[2:0] && reg_kind_o == {1'b1, d_q})
    else $error("full register wrong");
  a_sib_expect: assert property (took_q && !reg_op_o |->
    sib_used_o == (a_q && m_q[2:0] == 3'h4))
    else $error("sib use wrong");
  a_scale_index: assert property (took_q && sib_used_o |->
    scale_o == s_q[7:6] && index_vld_o == (s_q[5:3] != 3'h4))
    else $error("scale or index wrong");
  a_sib_base: assert property (took_q && sib_used_o &&
    !(m_q[7:6] == 2'h0 && s_q[2:0] == 3'h5) |->
    base_vld_o && base_o == s_q[2:0])
    else $error("sib base wrong");
  a_disp_len: assert property (
    took_q && !reg_op_o |-> disp_len_o == dl)
    else $error("displacement length wrong");
  a_stack_seg: assert property (took_q && !reg_op_o |->
    seg_stack_o == (base_vld_o &&
    ((base_o == 3'h5 && (!a_q || m_q[7:6] != 2'h0)) ||
    (base_o == 3'h4 && sib_used_o))))
    else $error("segment default wrong");
  c_reg: cover property (took_q && reg_op_o);
  c_sib: cover property (took_q && sib_used_o);
  c_soft: cover property (res_valid_o && !took_q);
endmodule
bind eamd_top eamd_top_asserts u_chk (
  .clk_i, .rst_b_i, .dec_valid_i, .modrm_i, .sib_i, .addr32_i, .data32_i,
  .width_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i,
  .res_valid_o, .reg_op_o, .reg_num_o, .reg_kind_o, .base_vld_o, .base_o,
  .index_vld_o, .scale_o, .disp_len_o, .seg_stack_o, .sib_used_o
);

// ---- eamd_dec_stage_model.sv ----
// Opcode decode stage model that feeds addressing bytes to the decoder.
`timescale 1ns/100ps
module eamd_dec_stage_model (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        send_i,
  input  wire logic        bad_ok_i,
  input  wire logic [18:0] op_i,
  output logic             dec_valid_o,
  output wire       [7:0]  modrm_o,
  output wire       [7:0]  sib_o,
  output wire              addr32_o,
  output wire              data32_o,
  output wire              width_o
);
  logic [18:0] op_q;
  assign {width_o, data32_o, addr32_o, sib_o, modrm_o} = op_q;
  // Idle cycles toggle the bytes so that a decoder sampling them late fails.
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      dec_valid_o <= 1'b0;
      op_q <= 19'h00000;
    end else if (send_i) begin
      dec_valid_o <= 1'b1;
      op_q <= op_i;
      if (op_i[13:11] == 3'h4 && !bad_ok_i)
        op_q[15:14] <= 2'h0;
    end else begin
      dec_valid_o <= 1'b0;
      op_q <= ~op_q;
    end
  end
endmodule

// ---- eamd_top_tb_top.sv ----
// Self-checking testbench for the effective address mode decoder.
`timescale 1ns/100ps
module eamd_top_tb_top;
  logic        clk_i, rst_b_i, send, bad_ok, sw, hsel_i, hwrite_i;
  logic [18:0] op, v;
  logic [31:0] haddr_i, hwdata_i, rd;
  logic [1:0]  htrans_i;
  logic [43:0] e, me;
  logic [43:0] q[$];
  int          bad_count, samples_checked, n_dec, i, j;
  wire         dec_valid_i, addr32_i, data32_i, width_i, res_valid_o;
  wire         reg_op_o, base_vld_o, index_vld_o, seg_stack_o, sib_used_o;
  wire         undef_o, hreadyout_o, hresp_o;
  wire  [7:0]  modrm_i, sib_i;
  wire  [2:0]  reg_num_o, base_o, index_o, disp_len_o;
  wire  [1:0]  reg_kind_o, scale_o;
  wire  [31:0] hrdata_o;
  wire  [21:0] rv = {undef_o, sib_used_o, seg_stack_o, disp_len_o, scale_o,
                     index_o, index_vld_o, base_o, base_vld_o, reg_kind_o,
                     reg_num_o, reg_op_o};
  eamd_top dut (
    .clk_i, .rst_b_i, .dec_valid_i, .modrm_i, .sib_i, .addr32_i, .data32_i,
    .width_i, .res_valid_o, .reg_op_o, .reg_num_o, .reg_kind_o, .base_vld_o,
    .base_o, .index_vld_o, .index_o, .scale_o, .disp_len_o, .seg_stack_o,
    .sib_used_o, .undef_o, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
    .hreadyout_o, .hresp_o);
  eamd_dec_stage_model u_src (
    .clk_i, .rst_b_i, .send_i(send), .bad_ok_i(bad_ok), .op_i(op),
    .dec_valid_o(dec_valid_i), .modrm_o(modrm_i), .sib_o(sib_i),
    .addr32_o(addr32_i), .data32_o(data32_i), .width_o(width_i));
  ////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Returns the care mask above the expected result word.
  function automatic [43:0] expf(input [18:0] o);
    reg [1:0] md;
    reg [2:0] rm, b, x;
    reg [21:0] r, m;
    begin
      md = o[7:6]; rm = o[2:0]; b = o[10:8]; x = o[13:11];
      r = 22'h0; m = 22'h3FFFFF;
      if (md == 2'h3) begin
        r[0] = 1'b1;
        r[3:1] = o[18] ? rm : {1'b0, rm[1:0]};
        r[5:4] = o[18] ? {1'b1, o[17]} : {1'b0, rm[2]};
      end else if (!o[16]) begin
        r[18:16] = (md == 2'h1) ? 3'h1 :
                   (md == 2'h2 || rm == 3'h6) ? 3'h2 : 3'h0;
        r[6] = !(md == 2'h0 && rm == 3'h6);
        r[9:7] = rm[2] ? ((rm == 3'h4) ? 3'h6 : (rm == 3'h5) ? 3'h7 :
                 (rm == 3'h6) ? 3'h5 : 3'h3) : (rm[1] ? 3'h5 : 3'h3);
        r[10] = !rm[2];
        r[13:11] = rm[0] ? 3'h7 : 3'h6;
        r[19] = r[6] && r[9:7] == 3'h5;
      end else begin
        r[18:16] = (md == 2'h1) ? 3'h1 : (md == 2'h2) ? 3'h4 : 3'h0;
        if (rm == 3'h4) begin
          r[20] = 1'b1;
          r[15:14] = o[15:14];
          r[10] = x != 3'h4;
          r[13:11] = x;
          r[21] = x == 3'h4 && o[15:14] != 2'h0;
          r[6] = !(md == 2'h0 && b == 3'h5);
          r[9:7] = b;
        end else begin
          r[6] = !(md == 2'h0 && rm == 3'h5);
          r[9:7] = rm;
        end
        if (!r[6]) r[18:16] = 3'h4;
        r[19] = r[6] && ((r[9:7] == 3'h4 && r[20]) ||
                         (r[9:7] == 3'h5 && md != 2'h0));
      end
      if (!r[6]) m[9:7] = 3'h0;
      if (!r[10]) m[13:11] = 3'h0;
      expf = {m, r};
    end
  endfunction
  task chk(input logic [31:0] s, input logic [31:0] x, input logic [31:0] m);
    samples_checked++;
    if ((s & m) !== (x & m)) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
    chk({31'h0, hresp_o}, 32'h0, 32'h1);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    ahb(1'b0, a, 32'h0);
    chk(rd, x, m);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////
  always @(posedge clk_i) begin
    if (res_valid_o === 1'b1) begin
      if (q.size() == 0) chk(32'h1, 32'h0, 32'h1);
      else begin
        me = q.pop_front();
        me = {me[43:22], me[21:0]};
        chk({10'h0, rv}, {10'h0, me[21:0]}, {10'h0, me[43:22]});
      end
    end
    if (dec_valid_i === 1'b1 && !sw && rst_b_i) begin
      q.push_back(expf({width_i, data32_i, addr32_i, sib_i, modrm_i}));
      n_dec++;
    end
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    test_done;
  end
  initial begin
    {rst_b_i, send, bad_ok, sw, hsel_i, hwrite_i, htrans_i} = 8'h00;
    {op, haddr_i, hwdata_i, bad_count, samples_checked, n_dec} = 0;
    void'($urandom(32'hB9AC));
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    chk({9'h0, res_valid_o, rv}, 32'h0, 32'hFFFFFFFF);
    ahb(1'b1, 8'h10, 32'hFFFFFFFF);
    for (i = 0; i < 5; i++) rchk({i[5:0], 2'h0}, 32'h0, 32'hFFFFFFFF);
    $display("test reset done");
    for (i = 0; i < 2848; i++) begin
      @(posedge clk_i);
      bad_ok <= i >= 2448;
      send <= (i < 2048) ? 1'b1 : 1'($urandom);
      if (i < 2048) op <= {i[10:8], 8'($urandom), i[7:0]};
      else if (i < 2448) op <= 19'($urandom);
      else op <= {3'($urandom), 2'($urandom), 3'h4, 6'($urandom), 5'h04};
    end
    @(posedge clk_i);
    send <= 1'b0;
    repeat (4) @(posedge clk_i);
    $display("test pipeline done");
    ahb(1'b1, 8'h00, 32'h1);
    sw <= 1'b1;
    @(posedge clk_i);
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
    for (i = 0; i < 6; i++) begin
      v = (i == 0) ? 19'h5A4C4 : 19'($urandom);
      ahb(1'b1, 8'h04, {13'h0, v});
      e = expf(v);
      q.push_back(e);
      n_dec++;
      for (j = 0; j < 20 && q.size() != 0; j++) @(posedge clk_i);
      rchk(8'h04, {13'h0, v}, 32'hFFFFFFFF);
      rchk(8'h08, {10'h0, e[21:0]}, {10'h0, e[43:22]});
      rchk(8'h0C, {n_dec[15:0], 14'h0, e[21], 1'b1}, 32'hFFFF0003);
      ahb(1'b1, 8'h0C, 32'h1);
      rchk(8'h0C, 32'h0, 32'h1);
    end
    ahb(1'b1, 8'h00, 32'h0);
    sw <= 1'b0;
    @(posedge clk_i);
    send <= 1'b1;
    op <= 19'h500A4;
    @(posedge clk_i);
    send <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(q.size(), 32'h0, 32'hFFFFFFFF);
    $display("test software decode done");
    test_done;
  end
endmodule
